/* hdl/uart_transmit_path.sv */
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "uart_tx_consts.svh"

module uart_transmit_path (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic rxd_i,
  input wire logic [7:0] rx_data_i,
  input wire logic overrun_flag_i,
  input wire logic noise_flag_i,
  input wire logic framing_error_flag_i,
  input wire logic parity_error_flag_i,
  output logic err_clear_o,
  output logic rx_sample_o,
  output logic err_irq_o,
  output logic txd_o,
  output logic txd_oe_o
);
  import uart_tx_pkg::*;

  top_state_t st_r;
  top_state_t st_nxt;
  logic tx_tick;
  logic sh_line;
  logic sh_busy;
  logic sh_last;
  logic ld;
  tx_kind_t ld_kind;
  logic set_idle;
  logic set_brk;
  logic take;
  logic [31:0] rd;
  logic [3:0] flags;
  logic [3:0] enables;

  // ==========================================================
  // shared baud generator and frame shifter
  baud_tick_gen u_baud (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .divisor_i(st_r.baud),
    .rxd_i(rxd_i),
    .tx_tick_o(tx_tick),
    .rx_sample_o(rx_sample_o)
  );

  tx_frame_shifter u_shift (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .load_i(ld),
    .tick_i(tx_tick),
    .nine_bit_i(st_r.ctrl2[`UTX_C2_M]),
    .long_break_i(st_r.ctrl2[`UTX_C2_LONG_BREAK]),
    .kind_i(ld_kind),
    .data_i(st_r.txbuf),
    .line_o(sh_line),
    .busy_o(sh_busy),
    .last_o(sh_last)
  );

  // error flags and their enables, bit 3 down to 0
  assign flags = {overrun_flag_i, noise_flag_i, framing_error_flag_i, parity_error_flag_i};
  assign enables = st_r.ctrl3[`UTX_C3_OVR_IE:`UTX_C3_PARITY_IE];
  assign take = hsel_i && htrans_i[1] && hready_i;

  // ==========================================================
  // bus slave, queues and transmit control
  always_comb begin
    st_nxt = st_r;
    ld = 1'b0;
    ld_kind = KIND_DATA;
    set_idle = 1'b0;
    set_brk = 1'b0;
    rd = 32'h0000_0000;
    st_nxt.err_clr = 1'b0;
    st_nxt.ready = 1'b1;
    st_nxt.resp = 1'b0;

    // write data phase, one cycle after the address phase
    if (st_r.ap_valid && st_r.ap_write) begin
      case (st_r.ap_addr)
        `UTX_OFS_CTRL2: begin
          st_nxt.ctrl2 = hwdata_i[7:0] & `UTX_C2_MASK;
          if (hwdata_i[`UTX_C2_TX_EN] && !st_r.ctrl2[`UTX_C2_TX_EN]) begin
            set_idle = 1'b1;
          end
          if (hwdata_i[`UTX_C2_SEND_BREAK] && !st_r.ctrl2[`UTX_C2_SEND_BREAK]) begin
            set_brk = 1'b1;
          end
        end
        `UTX_OFS_CTRL3: begin
          st_nxt.ctrl3 = hwdata_i[7:0] & `UTX_C3_MASK;
        end
        `UTX_OFS_DATA: begin
          // ninth bit is captured with the byte
          st_nxt.txbuf = {st_r.ctrl3[`UTX_C3_NINTH], hwdata_i[7:0]};
          st_nxt.pending = 1'b1;
          if (st_r.armed) begin
            st_nxt.buf_empty = 1'b0;
            st_nxt.tc = 1'b0;
          end
          st_nxt.armed = 1'b0;
        end
        `UTX_OFS_BAUD: begin
          st_nxt.baud = hwdata_i[12:0];
        end
        default: begin
        end
      endcase
    end

    // read answer prepared in the address phase
    if (take && !hwrite_i) begin
      case (haddr_i[7:0])
        `UTX_OFS_CTRL2: rd = {24'h00_0000, st_r.ctrl2};
        `UTX_OFS_CTRL3: rd = {24'h00_0000, st_r.ctrl3};
        `UTX_OFS_STAT: begin
          rd = {24'h00_0000, st_r.buf_empty, st_r.tc, 2'b00, flags};
          st_nxt.armed = 1'b1;
        end
        `UTX_OFS_DATA: begin
          rd = {24'h00_0000, rx_data_i};
          st_nxt.err_clr = st_r.armed;
          st_nxt.armed = 1'b0;
        end
        `UTX_OFS_BAUD: rd = {19'h0_0000, st_r.baud};
        default: rd = 32'h0000_0000;
      endcase
    end
    st_nxt.hrdata = rd;
    st_nxt.ap_valid = take;
    st_nxt.ap_write = hwrite_i;
    st_nxt.ap_addr = haddr_i[7:0];

    // shifter load on a baud tick when free: idle, then break, then data
    if (tx_tick && (!sh_busy || sh_last)) begin
      if (st_r.idle_q) begin
        ld = 1'b1;
        ld_kind = KIND_IDLE;
        st_nxt.idle_q = 1'b0;
      end else if (st_r.brk_q) begin
        ld = 1'b1;
        ld_kind = KIND_BREAK;
        st_nxt.brk_q = st_r.ctrl2[`UTX_C2_SEND_BREAK];
      end else if (st_r.pending && st_r.ctrl2[`UTX_C2_TX_EN]) begin
        ld = 1'b1;
        ld_kind = KIND_DATA;
        st_nxt.pending = 1'b0;
        st_nxt.buf_empty = 1'b1;
      end else if (sh_last) begin
        st_nxt.tc = 1'b1;
      end
    end

    // queue requests after the load so a new one is never dropped
    if (set_idle) begin
      st_nxt.idle_q = 1'b1;
      st_nxt.tc = 1'b0;
    end
    if (set_brk) begin
      st_nxt.brk_q = 1'b1;
      st_nxt.tc = 1'b0;
    end

    // error request from gated flags
    st_nxt.irq = |(flags & enables);

    // pin held while the transmitter is enabled, a frame is in flight, or an idle or break is queued
    st_nxt.oe = st_nxt.ctrl2[`UTX_C2_TX_EN] || sh_busy || ld ||
                st_nxt.idle_q || st_nxt.brk_q;
    st_nxt.txd = sh_line ^ st_r.ctrl3[`UTX_C3_INVERT];
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '{ctrl2: `UTX_C2_RST, ctrl3: `UTX_C3_RST, baud: `UTX_BAUD_RST,
                txbuf: 9'h000, pending: 1'b0, buf_empty: 1'b1, tc: 1'b1, idle_q: 1'b0,
                brk_q: 1'b0, armed: 1'b0, ap_valid: 1'b0, ap_write: 1'b0,
                ap_addr: 8'h00, hrdata: 32'h0000_0000, ready: 1'b1, resp: 1'b0,
                irq: 1'b0, txd: 1'b1, oe: 1'b0, err_clr: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata_o = st_r.hrdata;
  assign hreadyout_o = st_r.ready;
  assign hresp_o = st_r.resp;
  assign err_clear_o = st_r.err_clr;
  assign err_irq_o = st_r.irq;
  assign txd_o = st_r.txd;
  assign txd_oe_o = st_r.oe;

  // ==========================================================
  // checks
  property p_idle_level;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (!sh_busy && $past(!sh_busy)) |=> (txd_o == !$past(st_r.ctrl3[`UTX_C3_INVERT]));
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("idle level does not follow inversion");

  property p_irq_ovr;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (overrun_flag_i && st_r.ctrl3[`UTX_C3_OVR_IE]) |=> err_irq_o;
  endproperty
  a_irq_ovr: assert property (p_irq_ovr)
    else $error("enabled overrun gave no request");

  property p_irq_noise;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (noise_flag_i && st_r.ctrl3[`UTX_C3_NOISE_IE]) |=> err_irq_o;
  endproperty
  a_irq_noise: assert property (p_irq_noise)
    else $error("enabled noise flag gave no request");

  property p_irq_frame;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (framing_error_flag_i && st_r.ctrl3[`UTX_C3_FRAME_IE]) |=> err_irq_o;
  endproperty
  a_irq_frame: assert property (p_irq_frame)
    else $error("enabled framing error gave no request");

  property p_irq_parity;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (parity_error_flag_i && st_r.ctrl3[`UTX_C3_PARITY_IE]) |=> err_irq_o;
  endproperty
  a_irq_parity: assert property (p_irq_parity)
    else $error("enabled parity error gave no request");

  property p_irq_quiet;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    ((flags & enables) == 4'h0) |=> !err_irq_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("request raised with no enabled flag");

  property p_empty_on_load;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (ld && ld_kind == KIND_DATA) |=> (st_r.buf_empty && !st_r.pending);
  endproperty
  a_empty_on_load: assert property (p_empty_on_load)
    else $error("buffer-empty not set on shifter load");

  property p_tc_end;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (tx_tick && sh_last && !ld) |=> st_r.tc ##1 txd_o == !st_r.ctrl3[`UTX_C3_INVERT];
  endproperty
  a_tc_end: assert property (p_tc_end)
    else $error("transmit complete missing after stop bit");

  property p_pin_held;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    sh_busy |=> txd_oe_o;
  endproperty
  a_pin_held: assert property (p_pin_held)
    else $error("pin released while shifter busy");

  property p_brk_again;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (ld && ld_kind == KIND_BREAK && st_r.ctrl2[`UTX_C2_SEND_BREAK]) |=> st_r.brk_q;
  endproperty
  a_brk_again: assert property (p_brk_again)
    else $error("held send_break did not queue another break");

  property p_preamble;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    set_idle |=> st_r.idle_q [*1] ##0 txd_oe_o;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("enable rise did not queue idle");

  property p_brk_queue;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    set_brk |=> st_r.brk_q;
  endproperty
  a_brk_queue: assert property (p_brk_queue)
    else $error("send_break rise did not queue a break");

  // first bit of a loaded frame reaches the pin two clocks after the load
  property p_start_low;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (ld && ld_kind == KIND_DATA) |-> ##2 (txd_o == $past(st_r.ctrl3[`UTX_C3_INVERT]));
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("data frame did not open with a start bit");

  property p_brk_low;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (ld && ld_kind == KIND_BREAK) |-> ##2 (txd_o == $past(st_r.ctrl3[`UTX_C3_INVERT]));
  endproperty
  a_brk_low: assert property (p_brk_low)
    else $error("break did not drive the line to space");

  property p_idle_high;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (ld && ld_kind == KIND_IDLE) |-> ##2 (txd_o != $past(st_r.ctrl3[`UTX_C3_INVERT]));
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("idle character did not hold the line at mark");

  // ninth bit is taken from the control field at the data write
  property p_ninth;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (st_r.ap_valid && st_r.ap_write && st_r.ap_addr == `UTX_OFS_DATA) |=>
      (st_r.txbuf[8] == $past(st_r.ctrl3[`UTX_C3_NINTH]));
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth bit not captured with the data write");

endmodule : uart_transmit_path

/* shared/uart_tx_consts.svh */
`ifndef UART_TX_CONSTS_SVH
`define UART_TX_CONSTS_SVH

// ==========================================================
// register byte offsets
`define UTX_OFS_CTRL2 8'h00
`define UTX_OFS_CTRL3 8'h04
`define UTX_OFS_DATA 8'h08
`define UTX_OFS_STAT 8'h0C
`define UTX_OFS_BAUD 8'h10

// ==========================================================
// control_register_two fields
`define UTX_C2_SEND_BREAK 0
`define UTX_C2_TX_EN 3
`define UTX_C2_M 4
`define UTX_C2_LONG_BREAK 5
`define UTX_C2_MASK 8'h39
`define UTX_C2_RST 8'h00

// ==========================================================
// control_register_three fields
`define UTX_C3_NINTH 6
`define UTX_C3_INVERT 4
`define UTX_C3_OVR_IE 3
`define UTX_C3_NOISE_IE 2
`define UTX_C3_FRAME_IE 1
`define UTX_C3_PARITY_IE 0
`define UTX_C3_MASK 8'h5F
`define UTX_C3_RST 8'h00

// ==========================================================
// baud divisor
`define UTX_BAUD_RST 13'h0004
`define UTX_OS_LAST 4'hF
`define UTX_RX_SAMPLE_PH 4'h8

// ==========================================================
// frame lengths in bit times
`define UTX_LEN8 4'hA
`define UTX_LEN9 4'hB
`define UTX_BRK_LONG8 4'hD
`define UTX_BRK_LONG9 4'hE

`endif

/* shared/uart_tx_pkg.sv */
package uart_tx_pkg;

  // ==========================================================
  // kinds of character the shifter can send
  typedef enum logic [1:0] {
    KIND_DATA = 2'b00,
    KIND_IDLE = 2'b01,
    KIND_BREAK = 2'b10
  } tx_kind_t;

  // ==========================================================
  // module state records
  typedef struct packed {
    logic [12:0] div_cnt;
    logic [3:0] os_cnt;
    logic [3:0] rx_ph;
    logic rxd_prev;
    logic tx_tick;
    logic rx_smp;
  } baud_state_t;

  typedef struct packed {
    logic [10:0] shift;
    logic [3:0] cnt;
    logic fill;
    logic busy;
  } shift_state_t;

  typedef struct packed {
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [12:0] baud;
    logic [8:0] txbuf;
    logic pending;
    logic buf_empty;
    logic tc;
    logic idle_q;
    logic brk_q;
    logic armed;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic ready;
    logic resp;
    logic irq;
    logic txd;
    logic oe;
    logic err_clr;
  } top_state_t;

endpackage : uart_tx_pkg

/* hdl/baud_tick_gen.sv */
`timescale 1ns/1ps
`include "uart_tx_consts.svh"

module baud_tick_gen (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [12:0] divisor_i,
  input wire logic rxd_i,
  output logic tx_tick_o,
  output logic rx_sample_o
);
  import uart_tx_pkg::*;

  baud_state_t st_r;
  baud_state_t st_nxt;
  logic os_tick;

  // ==========================================================
  // one divider off the bus clock feeds both directions
  always_comb begin
    st_nxt = st_r;
    os_tick = 1'b0;
    st_nxt.tx_tick = 1'b0;
    st_nxt.rx_smp = 1'b0;
    st_nxt.rxd_prev = rxd_i;
    if (divisor_i != 13'h0000) begin
      if (st_r.div_cnt == 13'h0000) begin
        os_tick = 1'b1;
        st_nxt.div_cnt = divisor_i - 13'h0001;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt - 13'h0001;
      end
    end
    if (os_tick) begin
      st_nxt.os_cnt = st_r.os_cnt + 4'h1;
      st_nxt.tx_tick = (st_r.os_cnt == `UTX_OS_LAST);
      st_nxt.rx_ph = st_r.rx_ph + 4'h1;
      st_nxt.rx_smp = (st_r.rx_ph == `UTX_RX_SAMPLE_PH);
    end
    // every falling edge on the serial input realigns the bit phase
    if (st_r.rxd_prev && !rxd_i) begin
      st_nxt.rx_ph = 4'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '{div_cnt: 13'h0000, os_cnt: 4'h0, rx_ph: 4'h0, rxd_prev: 1'b1,
                tx_tick: 1'b0, rx_smp: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tx_tick_o = st_r.tx_tick;
  assign rx_sample_o = st_r.rx_smp;

endmodule : baud_tick_gen

/* hdl/tx_frame_shifter.sv */
`timescale 1ns/1ps
`include "uart_tx_consts.svh"

module tx_frame_shifter (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic tick_i,
  input wire logic nine_bit_i,
  input wire logic long_break_i,
  input uart_tx_pkg::tx_kind_t kind_i,
  input wire logic [8:0] data_i,
  output logic line_o,
  output logic busy_o,
  output logic last_o
);
  import uart_tx_pkg::*;

  shift_state_t st_r;
  shift_state_t st_nxt;
  logic [3:0] len;

  // ==========================================================
  // frame build on load, one bit per baud tick afterwards
  always_comb begin
    st_nxt = st_r;
    len = nine_bit_i ? `UTX_LEN9 : `UTX_LEN8;
    if (load_i) begin
      st_nxt.busy = 1'b1;
      st_nxt.fill = (kind_i != KIND_BREAK);
      st_nxt.cnt = len;
      case (kind_i)
        KIND_DATA: begin
          // start bit low, data lsb first, stop bit high
          st_nxt.shift = nine_bit_i ? {1'b1, data_i, 1'b0}
                                    : {2'b11, data_i[7:0], 1'b0};
        end
        KIND_BREAK: begin
          st_nxt.shift = 11'h000;
          if (long_break_i) begin
            st_nxt.cnt = nine_bit_i ? `UTX_BRK_LONG9 : `UTX_BRK_LONG8;
          end
        end
        default: begin
          st_nxt.shift = 11'h7FF;
        end
      endcase
    end else if (tick_i && st_r.busy) begin
      st_nxt.shift = {st_r.fill, st_r.shift[10:1]};
      st_nxt.cnt = st_r.cnt - 4'h1;
      if (st_r.cnt == 4'h1) begin
        st_nxt.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '{shift: 11'h7FF, cnt: 4'h0, fill: 1'b1, busy: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign line_o = st_r.busy ? st_r.shift[0] : 1'b1;
  assign busy_o = st_r.busy;
  assign last_o = st_r.busy && (st_r.cnt == 4'h1);

endmodule : tx_frame_shifter

/* dv/uart_rx_model.sv */
`timescale 1ns/1ps

// ==========================================================
// remote receiver: decodes frames at mid bit and times low runs
module uart_rx_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic nine_i,
  output logic [8:0] data_o,
  output logic stop_o,
  output int frames_o,
  output int run_o,
  output int runs_o
);
  int low_cnt;
  int nbits;

  // length of every low stretch, in clocks
  initial begin
    low_cnt = 0;
    run_o = 0;
    runs_o = 0;
    forever begin
      @(posedge clk_i);
      if (line_i === 1'b0) begin
        low_cnt++;
      end else if (low_cnt != 0) begin
        run_o = low_cnt;
        runs_o++;
        low_cnt = 0;
      end
    end
  end

  // frame decoder; a start bit high at mid bit is a glitch
  initial begin
    frames_o = 0;
    data_o = '0;
    stop_o = 1'b1;
    forever begin
      @(posedge clk_i);
      if (line_i === 1'b0) begin
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        if (line_i === 1'b0) begin
          nbits = nine_i ? 9 : 8;
          data_o = '0;
          for (int i = 0; i < nbits; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            data_o[i] = line_i;
          end
          repeat (BIT_CLKS) @(posedge clk_i);
          stop_o = line_i;
          frames_o++;
        end
        while (line_i !== 1'b1) @(posedge clk_i);
      end
    end
  end
endmodule : uart_rx_model

/* dv/tb_top.sv */
`timescale 1ns/1ps
`include "uart_tx_consts.svh"

module tb_top;
  import uart_tx_pkg::*;
  localparam int BIT = 16;
  localparam int LIMIT = 40000;
  logic core_clk, arst_n, hsel, hwrite, rxd, inv, nine, line;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic hreadyout, hresp, err_clear, rx_sample, err_irq, txd, txd_oe;
  logic [7:0] rx_data;
  logic [3:0] flags;
  logic [8:0] rx_char;
  logic rx_stop;
  int frames, run, runs, n_errors, num_checks, cycles, clr_cnt;

  // released pin is pulled up; inversion undone for the receiver
  assign line = txd_oe ? (txd ^ inv) : 1'b1;

  uart_transmit_path uart_transmit_path_inst (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .rxd_i(rxd), .rx_data_i(rx_data), .overrun_flag_i(flags[3]),
    .noise_flag_i(flags[2]), .framing_error_flag_i(flags[1]),
    .parity_error_flag_i(flags[0]), .err_clear_o(err_clear), .rx_sample_o(rx_sample),
    .err_irq_o(err_irq), .txd_o(txd), .txd_oe_o(txd_oe)
  );

  uart_rx_model #(.BIT_CLKS(BIT)) uart_rx_model_inst (
    .clk_i(core_clk), .line_i(line), .nine_i(nine), .data_o(rx_char),
    .stop_o(rx_stop), .frames_o(frames), .run_o(run), .runs_o(runs)
  );

  // ==========================================================
  // clock, watchdog, clear pulse counter
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (err_clear === 1'b1) clr_cnt++;
    if (cycles == LIMIT) begin
      n_errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h00000000, r);
  endtask : rd

  // poll status until the given bit is set
  task automatic wait_stat(input int b);
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      rd(`UTX_OFS_STAT, r);
      k++;
    end while (r[b] !== 1'b1 && k < 2000);
    check("status poll", r[b], 1'b1);
  endtask : wait_stat

  task automatic wait_frame(input int target);
    int k;
    k = 0;
    while (frames < target && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    check("frame count", frames, target);
  endtask : wait_frame

  task automatic wait_run(input int r0);
    int k;
    k = 0;
    while (runs == r0 && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
  endtask : wait_run

  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] r;
    check("txd idle", txd, 1'b1);
    check("pin released", txd_oe, 1'b0);
    rd(`UTX_OFS_CTRL2, r);
    check("ctrl2 reset", r, 32'h00000000);
    rd(`UTX_OFS_CTRL3, r);
    check("ctrl3 reset", r, 32'h00000000);
    rd(`UTX_OFS_BAUD, r);
    check("baud reset", r, 32'h00000004);
    rd(`UTX_OFS_STAT, r);
    check("status reset", r, 32'h000000C0);
    rd(8'h14, r);
    check("unmapped read", r, 32'h00000000);
    check("okay response", hresp, 1'b0);
  endtask : t_reset

  task automatic t_byte;
    logic [31:0] r;
    int f0;
    wr(`UTX_OFS_BAUD, 32'h00000001);
    wr(`UTX_OFS_CTRL2, 32'h00000008);
    f0 = frames;
    rd(`UTX_OFS_STAT, r);
    check("preamble queued", r[7:6], 2'b10);
    wr(`UTX_OFS_DATA, 32'h000000A5);
    rd(`UTX_OFS_STAT, r);
    check("buffer held", r[7], 1'b0);
    check("line idle in preamble", line, 1'b1);
    wait_frame(f0 + 1);
    check("byte lsb first", rx_char, 9'h0A5);
    check("stop bit", rx_stop, 1'b1);
    wait_stat(6);
    rd(`UTX_OFS_STAT, r);
    check("complete flags", r, 32'h000000C0);
    check("line idle after", line, 1'b1);
  endtask : t_byte

  task automatic t_nine;
    int f0;
    nine <= 1'b1;
    wr(`UTX_OFS_CTRL3, 32'h00000040);
    wr(`UTX_OFS_CTRL2, 32'h00000018);
    wait_stat(6);
    f0 = frames;
    wr(`UTX_OFS_DATA, 32'h0000003C);
    wait_stat(7);
    wr(`UTX_OFS_CTRL3, 32'h00000000);
    wr(`UTX_OFS_DATA, 32'h000000C3);
    wait_frame(f0 + 1);
    check("ninth bit set", rx_char, 9'h13C);
    wait_frame(f0 + 2);
    check("ninth bit clear", rx_char, 9'h0C3);
    wait_stat(6);
    nine <= 1'b0;
  endtask : t_nine

  task automatic t_break;
    logic [3:0] lens [4];
    logic [7:0] c2;
    int r0;
    lens = '{`UTX_LEN8, `UTX_LEN9, `UTX_BRK_LONG8, `UTX_BRK_LONG9};
    for (int i = 0; i < 4; i++) begin
      c2 = 8'h08 | (i[0] ? 8'h10 : 8'h00) | (i[1] ? 8'h20 : 8'h00);
      wr(`UTX_OFS_BAUD, 32'h00000000);
      wr(`UTX_OFS_CTRL2, {24'h000000, c2 | 8'h01});
      wr(`UTX_OFS_CTRL2, {24'h000000, c2});
      r0 = runs;
      wr(`UTX_OFS_BAUD, 32'h00000001);
      wait_run(r0);
      check("break length", run, lens[i] * BIT);
      wait_stat(6);
    end
    wr(`UTX_OFS_CTRL2, 32'h00000009);
    r0 = runs;
    repeat (5 * BIT) @(posedge core_clk);
    wr(`UTX_OFS_CTRL2, 32'h00000008);
    wait_run(r0);
    check("repeated break", run, 2 * `UTX_LEN8 * BIT);
    wait_stat(6);
  endtask : t_break

  task automatic t_invert;
    int f0;
    wr(`UTX_OFS_CTRL3, 32'h00000010);
    @(posedge core_clk);
    inv <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("inverted idle", txd, 1'b0);
    f0 = frames;
    wr(`UTX_OFS_DATA, 32'h0000005A);
    wait_frame(f0 + 1);
    check("inverted data", rx_char, 9'h05A);
    check("inverted stop", rx_stop, 1'b1);
    wait_stat(6);
    wr(`UTX_OFS_CTRL3, 32'h00000000);
    @(posedge core_clk);
    inv <= 1'b0;
  endtask : t_invert

  task automatic t_enable_off;
    logic [31:0] r;
    int f0;
    f0 = frames;
    wr(`UTX_OFS_DATA, 32'h00000081);
    wait_stat(7);
    wr(`UTX_OFS_CTRL2, 32'h00000000);
    repeat (4 * BIT) @(posedge core_clk);
    check("pin kept", txd_oe, 1'b1);
    wait_frame(f0 + 1);
    check("last byte", rx_char, 9'h081);
    wait_stat(6);
    repeat (4) @(posedge core_clk);
    check("pin released", txd_oe, 1'b0);
    wr(`UTX_OFS_CTRL2, 32'h00000008);
    rd(`UTX_OFS_STAT, r);
    check("idle queued", r[6], 1'b0);
    wait_stat(6);
  endtask : t_enable_off

  task automatic t_irq;
    logic [31:0] r;
    logic [3:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 4'h1 << i;
      flags <= m;
      wr(`UTX_OFS_CTRL3, {28'h0000000, m});
      repeat (2) @(posedge core_clk);
      check("irq enabled", err_irq, 1'b1);
      wr(`UTX_OFS_CTRL3, {28'h0000000, ~m});
      repeat (2) @(posedge core_clk);
      check("irq masked", err_irq, 1'b0);
      rd(`UTX_OFS_STAT, r);
      check("flag polled", r[3:0], m);
    end
    flags <= 4'h0;
    wr(`UTX_OFS_CTRL3, 32'h00000000);
  endtask : t_irq

  task automatic t_clear;
    logic [31:0] r;
    int c0;
    int f0;
    rx_data <= 8'h6E;
    c0 = clr_cnt;
    rd(`UTX_OFS_STAT, r);
    rd(`UTX_OFS_DATA, r);
    check("receive buffer", r, 32'h0000006E);
    repeat (2) @(posedge core_clk);
    check("clear pulse", clr_cnt, c0 + 1);
    rd(`UTX_OFS_DATA, r);
    repeat (2) @(posedge core_clk);
    check("no clear alone", clr_cnt, c0 + 1);
    f0 = frames;
    rd(`UTX_OFS_STAT, r);
    wr(`UTX_OFS_DATA, 32'h00000011);
    rd(`UTX_OFS_STAT, r);
    check("complete cleared", r[6], 1'b0);
    wait_frame(f0 + 1);
    check("write reached line", rx_char, 9'h011);
    wait_stat(6);
  endtask : t_clear

  // falling serial input edges at two phases realign the sample point
  task automatic t_resync;
    for (int j = 0; j < 2; j++) begin
      rxd <= 1'b0;
      repeat (`UTX_RX_SAMPLE_PH + 2) @(posedge core_clk);
      check("no early sample", rx_sample, 1'b0);
      @(posedge core_clk);
      check("realigned sample", rx_sample, 1'b1);
      rxd <= 1'b1;
      repeat (9 + j) @(posedge core_clk);
    end
  endtask : t_resync

  task automatic end_of_test;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // main sequence
  initial begin
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    clr_cnt = 0;
    arst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    rxd = 1'b1;
    rx_data = 8'h00;
    flags = 4'h0;
    inv = 1'b0;
    nine = 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_byte();
    t_nine();
    t_break();
    t_invert();
    t_enable_off();
    t_irq();
    t_clear();
    t_resync();
    end_of_test();
  end
endmodule : tb_top
